// ### testbench/cdcr_far_model.sv
// Far-side audio controller model: bit clock, frame clock and DAC data.
module cdcr_far_model (
  input wire logic go_i,
  input wire logic [7:0] nbits_i,
  output logic bck_o,
  output logic frame_o,
  output logic dac_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int half;
  int n;
  // Bit clock stands still until the controller is told to start.
  // At 48 or more bits per frame, each half frame ends with a word whose sign survives a one-bit slip:
  // left words are large positive, right words large negative.
  initial begin
    bck_o = 1'b0;
    frame_o = 1'b0;
    dac_o = 1'b1;
    wait (go_i === 1'b1);
    #5;
    forever begin
      // Frame length is taken once per frame, so a change never cuts one.
      n = int'(nbits_i);
      half = n / 2;
      for (int i = 0; i < n; i++) begin
        frame_o = (i < half);
        dac_o = (i < half) ? (i >= half - 22) : (i - half < half - 22);
        #16 bck_o = 1'b1;
        #16 bck_o = 1'b0;
      end
    end
  end
endmodule

// ### testbench/test_codec_clock_ratio_and_filter_control.sv
// Self-checking bench for the codec clock ratio and converter control.
module test_codec_clock_ratio_and_filter_control import cdcr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WAIT_FR = 4;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic adc_bit_l_i = 1'b0;
  logic adc_bit_r_i = 1'b0;
  logic por_core_ok_i = 1'b0;
  logic por_analog_ok_i = 1'b0;
  logic word_16b_i = 1'b0;
  logic go = 1'b0;
  logic [7:0] nbits = 8'h40;
  logic dc_mode = 1'b0;
  logic dc_val = 1'b1;
  wire serial_bit_clock, frame, dac_data;
  logic adc_data_o, mod_tick_o, adc_enable_o, run_o;
  logic [2:0] dac_level_l_o, dac_level_r_o, ratio_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ticks, sum_l, sum_r, wn;
  logic ones;
  logic [2:0] exp_q[$];
  cdcr_ratio_t codes[6] = '{CDCR_R128, CDCR_R192, CDCR_R256, CDCR_R512,
                            CDCR_R768, CDCR_R384};
  int lens[6] = '{16, 24, 32, 64, 96, 48};

  always #2 mclk_i = ~mclk_i;

  cdcr_top #(.ADC_WAIT_FRAMES(WAIT_FR)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .serial_bit_clock_i(serial_bit_clock),
    .frame_clock_i(frame), .dac_data_i(dac_data),
    .adc_bit_l_i(adc_bit_l_i), .adc_bit_r_i(adc_bit_r_i),
    .por_core_ok_i(por_core_ok_i), .por_analog_ok_i(por_analog_ok_i),
    .word_16b_i(word_16b_i), .adc_data_o(adc_data_o),
    .dac_level_l_o(dac_level_l_o), .dac_level_r_o(dac_level_r_o),
    .mod_tick_o(mod_tick_o), .ratio_o(ratio_o),
    .adc_enable_o(adc_enable_o), .run_o(run_o)
  );

  cdcr_far_model far (
    .go_i(go), .nbits_i(nbits), .bck_o(serial_bit_clock), .frame_o(frame),
    .dac_o(dac_data)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Counts strobes, sums DAC levels and looks for ones over one frame.
  task automatic measure();
    ticks = 0;
    sum_l = 0;
    sum_r = 0;
    ones = 1'b0;
    @(posedge frame);
    repeat (int'(nbits) * 8) begin
      @(negedge mclk_i);
      ones = ones | adc_data_o;
      if (mod_tick_o === 1'b1) begin
        ticks++;
        sum_l += dac_level_l_o;
        sum_r += dac_level_r_o;
      end
    end
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (run_o !== 1'b1 && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
  endtask

  // Modulator bit streams are random unless DC is forced; word width is always random.
  initial begin
    void'($urandom(32'h0000_04b9));
    forever begin
      @(posedge mclk_i);
      adc_bit_l_i <= dc_mode ? dc_val : 1'($urandom);
      adc_bit_r_i <= dc_mode ? dc_val : 1'($urandom);
      word_16b_i <= 1'($urandom);
    end
  end

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Every change of the detected ratio must match the oldest expectation.
  always @(ratio_o) begin
    if (rst_n_i === 1'b1) begin
      check(ratio_o, exp_q.size() ? exp_q.pop_front() : 3'h7);
    end
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    check({run_o, adc_enable_o, adc_data_o, mod_tick_o, ratio_o,
           dac_level_l_o, dac_level_r_o}, 13'h01a4);
    rst_n_i <= 1'b1;
    por_core_ok_i <= 1'b1;
    repeat (940) @(posedge mclk_i);
    exp_q.push_back(CDCR_R512);
    go <= 1'b1;
    repeat (4) @(posedge frame);
    check(run_o, 1'b0);
    @(posedge mclk_i);
    por_analog_ok_i <= 1'b1;
    wait_run(wn);
    check(wn >= 1027 && wn <= 1030, 1'b1);
    check(adc_enable_o, 1'b0);
    repeat (WAIT_FR - 1) @(posedge frame);
    check(adc_enable_o, 1'b0);
    repeat (3) @(posedge frame);
    check(adc_enable_o, 1'b1);
    for (int k = 0; k < 6; k++) begin
      exp_q.push_back(codes[k]);
      @(posedge mclk_i);
      nbits <= 8'(lens[k]);
      repeat (4) @(posedge frame);
      wait_run(wn);
      check(run_o, 1'b1);
      repeat (WAIT_FR + 2) @(posedge frame);
      measure();
      check(ticks, 64);
      check(adc_enable_o, k > 1);
      check(ones, k > 1);
    end
    @(posedge mclk_i);
    dc_mode <= 1'b1;
    repeat (4) @(posedge frame);
    @(posedge mclk_i);
    dc_val <= 1'b0;
    repeat (2) @(posedge frame);
    measure();
    check(ones, 1'b1);
    check(sum_l > 256, 1'b1);
    check(sum_r < 256, 1'b1);
    wn = 0;
    while (ones && wn < 170) begin
      measure();
      wn++;
    end
    check(ones, 1'b0);
    @(posedge mclk_i);
    por_core_ok_i <= 1'b0;
    repeat (8) @(negedge mclk_i);
    check({run_o, adc_enable_o}, 2'b00);
    check(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule

// ### verilog/cdcr_decim.sv
// One ADC channel: third-order decimator by 64 and DC-removal stage.
`include "cdcr_params.svh"
module cdcr_decim import cdcr_pkg::*; #(
  parameter int OW = `CDCR_WORD_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic bit_i,
  input wire logic tick_i,
  input wire logic dump_i,
  output logic [OW-1:0] word_o,
  output logic valid_o
);
  localparam int CW = 3 * $clog2(`CDCR_OSR) + 2;
  localparam int HW = OW + 2;
  generate
    if (OW < CW + 1) begin : g_chk
      $error("cdcr_decim: output word too narrow");
    end
  endgenerate
  logic signed [CW-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
  logic signed [HW-1:0] x1_q, y1_q;
  wire signed [CW-1:0] x_w = bit_i ? CW'(1) : -CW'(1);
  wire signed [CW-1:0] c1_w = i3_q - d1_q;
  wire signed [CW-1:0] c2_w = c1_w - d2_q;
  wire signed [CW-1:0] c3_w = c2_w - d3_q;
  // Full-scale comb output is scaled to the full output word range.
  wire signed [HW-1:0] xh_w = HW'(c3_w) <<< (OW - CW + 1);
  wire signed [HW-1:0] yh_w = xh_w - x1_q + y1_q
                              - (y1_q >>> `CDCR_HPF_SHIFT);
  wire fits_w = (&yh_w[HW-1:OW-1]) | ~(|yh_w[HW-1:OW-1]);
  wire [OW-1:0] sat_w = fits_w ? yh_w[OW-1:0]
                        : {yh_w[HW-1], {(OW-1){~yh_w[HW-1]}}};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      i1_q <= '0;
      i2_q <= '0;
      i3_q <= '0;
    end else if (tick_i) begin
      i1_q <= i1_q + x_w;
      i2_q <= i2_q + i1_q;
      i3_q <= i3_q + i2_q;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
      x1_q <= '0;
      y1_q <= '0;
      word_o <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= dump_i;
      if (dump_i) begin
        d1_q <= i3_q;
        d2_q <= c1_w;
        d3_q <= c2_w;
        x1_q <= xh_w;
        y1_q <= yh_w;
        word_o <= sat_w;
      end
    end
  end
endmodule

// ### verilog/cdcr_dsm.sv
// One DAC channel: interpolation by eight and 8-level fourth-order shaper.
`include "cdcr_params.svh"
module cdcr_dsm import cdcr_pkg::*; #(
  parameter int W = `CDCR_WORD_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [W-1:0] sample_i,
  output logic [2:0] level_o
);
  localparam int EW = W + 4;
  generate
    if (W < 8) begin : g_chk
      $error("cdcr_dsm: sample word too narrow");
    end
  endgenerate
  logic signed [W:0] cur_q, delta_q;
  logic [2:0] sub_q;
  logic signed [EW-1:0] e1_q, e2_q, e3_q, e4_q;
  wire signed [W:0] smp_w = (W+1)'($signed(sample_i));
  wire signed [EW-1:0] x_w = EW'(cur_q);
  wire signed [EW-1:0] fb_w = (e1_q <<< 2) - (e2_q <<< 2) - (e2_q <<< 1)
                              + (e3_q <<< 2) - e4_q;
  wire signed [EW-1:0] v_w = x_w - fb_w;
  wire signed [EW-1:0] vq_w = v_w >>> (W - 3);
  // Both bounds are signed so that the compare keeps the sign of vq_w.
  wire lo_w = vq_w < -$signed(EW'(4));
  wire hi_w = vq_w > $signed(EW'(3));
  wire [2:0] idx_w = lo_w ? 3'h0 : hi_w ? 3'h7
                     : (vq_w[2:0] ^ `CDCR_MID_LEVEL);
  wire signed [EW-1:0] lvl_w = $signed(EW'(idx_w))
                               - $signed(EW'(`CDCR_MID_LEVEL));
  wire signed [EW-1:0] qv_w = (lvl_w <<< (W - 3))
                              + $signed(EW'(1) << (W - 4));
  wire signed [EW-1:0] e_w = qv_w - v_w;
  // Clipping the stored error keeps the loop stable near full scale.
  wire signed [EW-1:0] lim_w = $signed(EW'(1) << (W - 3));
  wire signed [EW-1:0] es_w = e_w > lim_w ? lim_w
                              : e_w < -lim_w ? -lim_w : e_w;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_q <= '0;
      delta_q <= '0;
      sub_q <= 3'h0;
    end else if (load_i) begin
      delta_q <= (smp_w - cur_q) >>> 3;
    end else if (tick_i) begin
      sub_q <= sub_q + 3'h1;
      if (sub_q == 3'h7) begin
        cur_q <= cur_q + delta_q;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e1_q <= '0;
      e2_q <= '0;
      e3_q <= '0;
      e4_q <= '0;
      level_o <= `CDCR_MID_LEVEL;
    end else if (tick_i) begin
      e1_q <= es_w;
      e2_q <= e1_q;
      e3_q <= e2_q;
      e4_q <= e3_q;
      level_o <= idx_w;
    end
  end
endmodule

// ### verilog/cdcr_params.svh
// Constants for the codec clock ratio detector and converter paths.
`ifndef CDCR_PARAMS_SVH
`define CDCR_PARAMS_SVH
`define CDCR_FS_MIN_KHZ 8'h10
`define CDCR_FS_MAX_KHZ 8'hC0
`define CDCR_OSR 7'h40
`define CDCR_INTERP 4'h8
`define CDCR_WORD_W 24
`define CDCR_SHORT_W 16
`define CDCR_HPF_SHIFT 3
`define CDCR_MID_LEVEL 3'h4
`define CDCR_INIT_CYCLES 11'h0400
`define CDCR_ADC_WAIT_FRAMES 13'h1194
`define CDCR_CNT_MIN 10'h060
`define CDCR_CNT_B192 10'h0A0
`define CDCR_CNT_B256 10'h0E0
`define CDCR_CNT_B384 10'h140
`define CDCR_CNT_B512 10'h1C0
`define CDCR_CNT_B768 10'h280
`define CDCR_CNT_MAX 10'h380
`define CDCR_DIV_128 4'h2
`define CDCR_DIV_192 4'h3
`define CDCR_DIV_256 4'h4
`define CDCR_DIV_384 4'h6
`define CDCR_DIV_512 4'h8
`define CDCR_DIV_768 4'hC
`endif

// ### verilog/cdcr_pkg.sv
// Types shared by the codec clock ratio and converter control design.
package cdcr_pkg;
  typedef enum logic [2:0] {
    CDCR_R128, CDCR_R192, CDCR_R256, CDCR_R384, CDCR_R512, CDCR_R768,
    CDCR_RNONE
  } cdcr_ratio_t;
  typedef enum logic [1:0] {CDCR_WAIT, CDCR_INIT, CDCR_RUN} cdcr_init_t;
endpackage

// ### verilog/cdcr_top.sv
// Codec control: clock ratio detection, start-up, ADC and DAC paths, port.
`include "cdcr_params.svh"
module cdcr_top import cdcr_pkg::*; #(
  parameter int ADC_WAIT_FRAMES = `CDCR_ADC_WAIT_FRAMES,
  parameter int WORD_W = `CDCR_WORD_W
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic serial_bit_clock_i,
  input wire logic frame_clock_i,
  input wire logic dac_data_i,
  input wire logic adc_bit_l_i,
  input wire logic adc_bit_r_i,
  input wire logic por_core_ok_i,
  input wire logic por_analog_ok_i,
  input wire logic word_16b_i,
  output logic adc_data_o,
  output logic [2:0] dac_level_l_o,
  output logic [2:0] dac_level_r_o,
  output logic mod_tick_o,
  output logic [2:0] ratio_o,
  output logic adc_enable_o,
  output logic run_o
);
  generate
    if (ADC_WAIT_FRAMES < 1 || ADC_WAIT_FRAMES > 8191) begin : g_chk_w
      $error("cdcr_top: ADC wait out of range");
    end
    if (WORD_W < `CDCR_SHORT_W) begin : g_chk_d
      $error("cdcr_top: word narrower than short format");
    end
  endgenerate

  function automatic cdcr_ratio_t classify(input logic [9:0] n);
    if (n < `CDCR_CNT_MIN || n >= `CDCR_CNT_MAX) return CDCR_RNONE;
    else if (n < `CDCR_CNT_B192) return CDCR_R128;
    else if (n < `CDCR_CNT_B256) return CDCR_R192;
    else if (n < `CDCR_CNT_B384) return CDCR_R256;
    else if (n < `CDCR_CNT_B512) return CDCR_R384;
    else if (n < `CDCR_CNT_B768) return CDCR_R512;
    else return CDCR_R768;
  endfunction

  function automatic logic [3:0] div_of(input cdcr_ratio_t r);
    unique case (r)
      CDCR_R128: return `CDCR_DIV_128;
      CDCR_R192: return `CDCR_DIV_192;
      CDCR_R256: return `CDCR_DIV_256;
      CDCR_R384: return `CDCR_DIV_384;
      CDCR_R512: return `CDCR_DIV_512;
      CDCR_R768: return `CDCR_DIV_768;
      CDCR_RNONE: return `CDCR_DIV_768;
      default: return `CDCR_DIV_768;
    endcase
  endfunction

  // Master clock domain reset release and pin synchronisers.
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  logic [5:0] pin_s1_q, pin_s2_q;
  logic fr_d_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      fr_d_q <= 1'b0;
    end else begin
      pin_s1_q <= {frame_clock_i, adc_bit_l_i, adc_bit_r_i,
                   por_core_ok_i, por_analog_ok_i, word_16b_i};
      pin_s2_q <= pin_s1_q;
      fr_d_q <= pin_s2_q[5];
    end
  end
  wire fr_rise = pin_s2_q[5] & ~fr_d_q;
  wire por_ok = pin_s2_q[2] & pin_s2_q[1];
  wire short_fmt = pin_s2_q[0];

  // Ratio detector: master clocks per frame, classified at each frame.
  logic [9:0] per_cnt_q;
  cdcr_ratio_t ratio_q, prev_q;
  logic lock_q;
  wire cdcr_ratio_t ratio_new = classify(per_cnt_q);
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_q <= 10'h000;
      ratio_q <= CDCR_RNONE;
      prev_q <= CDCR_RNONE;
      lock_q <= 1'b0;
    end else if (fr_rise) begin
      per_cnt_q <= 10'h001;
      prev_q <= ratio_new;
      ratio_q <= ratio_new;
      lock_q <= (ratio_new == prev_q) && (ratio_new != CDCR_RNONE);
    end else if (per_cnt_q != 10'h3FF) begin
      per_cnt_q <= per_cnt_q + 10'h001;
    end
  end
  assign ratio_o = ratio_q;

  // Start-up sequence: both supplies good and clocks locked, then wait.
  cdcr_init_t st_q;
  logic [10:0] init_cnt_q;
  logic run_q;
  wire go = por_ok & lock_q;
  wire init_end = init_cnt_q == `CDCR_INIT_CYCLES - 11'h001;
  wire run_d = go && ((st_q == CDCR_INIT && init_end) || st_q == CDCR_RUN);
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= CDCR_WAIT;
      init_cnt_q <= 11'h000;
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
      unique case (st_q)
        CDCR_WAIT: begin
          init_cnt_q <= 11'h000;
          if (go) st_q <= CDCR_INIT;
        end
        CDCR_INIT: begin
          if (!go) st_q <= CDCR_WAIT;
          else if (init_end) st_q <= CDCR_RUN;
          else init_cnt_q <= init_cnt_q + 11'h001;
        end
        CDCR_RUN: begin
          if (!go) st_q <= CDCR_WAIT;
        end
      endcase
    end
  end
  assign run_o = run_q;

  // Modulator rate strobe: 64 per frame at any locked ratio, none while unlocked.
  logic [3:0] div_cnt_q;
  logic tick_q;
  logic [5:0] phase_q;
  wire [3:0] div_w = div_of(ratio_q);
  wire tick_now = div_cnt_q >= div_w - 4'h1;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 4'h0;
      tick_q <= 1'b0;
      phase_q <= 6'h00;
    end else begin
      div_cnt_q <= tick_now ? 4'h0 : div_cnt_q + 4'h1;
      tick_q <= tick_now & lock_q;
      if (tick_q) phase_q <= phase_q + 6'h01;
    end
  end
  assign mod_tick_o = tick_q;
  wire dump = tick_q && phase_q == 6'h3F;

  // ADC gating: ratio of 256 or more, running, and the settling frames counted.
  logic [12:0] adc_fr_q;
  logic adc_en_q;
  wire wait_done = adc_fr_q == ADC_WAIT_FRAMES[12:0];
  wire ratio_adc = ratio_q != CDCR_R128 && ratio_q != CDCR_R192
                   && ratio_q != CDCR_RNONE;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      adc_fr_q <= 13'h0000;
      adc_en_q <= 1'b0;
    end else begin
      if (!run_q) adc_fr_q <= 13'h0000;
      else if (fr_rise && !wait_done) adc_fr_q <= adc_fr_q + 13'h0001;
      adc_en_q <= run_q && wait_done && ratio_adc;
    end
  end
  assign adc_enable_o = adc_en_q;

  // Channel datapaths; index 0 is left, 1 is right.
  wire [1:0] adc_bit = {pin_s2_q[3], pin_s2_q[4]};
  logic [WORD_W-1:0] dec_word [2];
  logic [1:0] dec_vld;
  logic [WORD_W-1:0] adc_word_q [2];
  logic [WORD_W-1:0] dac_word_q [2];
  logic dac_ld_q;
  logic [2:0] level [2];
  wire [WORD_W-1:0] word_mask = short_fmt
    ? {{`CDCR_SHORT_W{1'b1}}, {(WORD_W - `CDCR_SHORT_W){1'b0}}} : '1;
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      cdcr_decim #(.OW(WORD_W)) u_dec (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .bit_i(adc_bit[c]),
        .tick_i(tick_q),
        .dump_i(dump),
        .word_o(dec_word[c]),
        .valid_o(dec_vld[c])
      );
      cdcr_dsm #(.W(WORD_W)) u_dsm (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .tick_i(tick_q),
        .load_i(dac_ld_q),
        .sample_i(dac_word_q[c]),
        .level_o(level[c])
      );
    end
  endgenerate
  assign dac_level_l_o = level[0];
  assign dac_level_r_o = level[1];

  // ADC words are held stable and announced to the port by a toggle.
  logic adc_tgl_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      adc_word_q[0] <= '0;
      adc_word_q[1] <= '0;
      adc_tgl_q <= 1'b0;
    end else if (dec_vld[0]) begin
      adc_word_q[0] <= adc_en_q ? dec_word[0] & word_mask : '0;
      adc_word_q[1] <= adc_en_q ? dec_word[1] & word_mask : '0;
      adc_tgl_q <= ~adc_tgl_q;
    end
  end

  // Link domain on the serial bit clock.
  logic b_rst1_q, b_rst2_q;
  always_ff @(posedge serial_bit_clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b_rst1_q <= 1'b0;
      b_rst2_q <= 1'b0;
    end else begin
      b_rst1_q <= 1'b1;
      b_rst2_q <= b_rst1_q;
    end
  end
  wire b_rst_n = b_rst2_q;

  logic ae_s1_q, ae_s2_q, at_s1_q, at_s2_q, at_s3_q;
  logic lr_q, lr_d_q, dac_tgl_q;
  logic [WORD_W-1:0] hold_q [2];
  logic [WORD_W-1:0] rx_hold_q [2];
  logic [WORD_W-1:0] tx_q, rx_q;
  wire lr_edge = lr_q ^ lr_d_q;
  wire adc_new = at_s2_q ^ at_s3_q;
  always_ff @(posedge serial_bit_clock_i or negedge b_rst_n) begin
    if (!b_rst_n) begin
      ae_s1_q <= 1'b0;
      ae_s2_q <= 1'b0;
      at_s1_q <= 1'b0;
      at_s2_q <= 1'b0;
      at_s3_q <= 1'b0;
      lr_q <= 1'b0;
      lr_d_q <= 1'b0;
      hold_q[0] <= '0;
      hold_q[1] <= '0;
    end else begin
      ae_s1_q <= adc_en_q;
      ae_s2_q <= ae_s1_q;
      at_s1_q <= adc_tgl_q;
      at_s2_q <= at_s1_q;
      at_s3_q <= at_s2_q;
      lr_q <= frame_clock_i;
      lr_d_q <= lr_q;
      if (adc_new) begin
        hold_q[0] <= adc_word_q[0];
        hold_q[1] <= adc_word_q[1];
      end
    end
  end

  // Shared port: frame high carries left, low carries right, MSB first.
  always_ff @(posedge serial_bit_clock_i or negedge b_rst_n) begin
    if (!b_rst_n) begin
      tx_q <= '0;
      rx_q <= '0;
      rx_hold_q[0] <= '0;
      rx_hold_q[1] <= '0;
      dac_tgl_q <= 1'b0;
      adc_data_o <= 1'b0;
    end else begin
      rx_q <= {rx_q[WORD_W-2:0], dac_data_i};
      adc_data_o <= ae_s2_q & tx_q[WORD_W-1];
      if (lr_edge) begin
        tx_q <= lr_q ? hold_q[0] : hold_q[1];
        if (lr_q) begin
          rx_hold_q[1] <= rx_q;
          dac_tgl_q <= ~dac_tgl_q;
        end else begin
          rx_hold_q[0] <= rx_q;
        end
      end else begin
        tx_q <= {tx_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  // DAC word pair crosses back on a toggle after the right word ends.
  logic dt_s1_q, dt_s2_q, dt_s3_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
      dt_s3_q <= 1'b0;
      dac_ld_q <= 1'b0;
      dac_word_q[0] <= '0;
      dac_word_q[1] <= '0;
    end else begin
      dt_s1_q <= dac_tgl_q;
      dt_s2_q <= dt_s1_q;
      dt_s3_q <= dt_s2_q;
      dac_ld_q <= dt_s2_q ^ dt_s3_q;
      if (dt_s2_q ^ dt_s3_q) begin
        dac_word_q[0] <= run_q ? rx_hold_q[0] : '0;
        dac_word_q[1] <= run_q ? rx_hold_q[1] : '0;
      end
    end
  end

  ratio_disable_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (ratio_q == CDCR_R128 || ratio_q == CDCR_R192) |=> !adc_en_q)
    else $error("ADC enabled at a low clock ratio");
  dout_low_a: assert property (
    @(posedge serial_bit_clock_i) disable iff (!b_rst_n)
    !ae_s2_q |=> !adc_data_o)
    else $error("ADC output not low while disabled");
  init_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(run_q) |-> $past(st_q) == CDCR_INIT
                     && $past(init_cnt_q) == `CDCR_INIT_CYCLES - 11'h001)
    else $error("run started before the start-up count ended");
  por_both_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !por_ok |=> !run_q)
    else $error("running without both supplies good");
  adc_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(adc_en_q) |-> $past(adc_fr_q) == ADC_WAIT_FRAMES[12:0]
                        && $past(run_q))
    else $error("ADC enabled before settling frames");
  tick_gap_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    tick_q && ratio_q == CDCR_R128 && lock_q && $stable(ratio_q)
    |=> !tick_q ##1 (tick_q || !lock_q || $changed(ratio_q)))
    else $error("modulator strobe not at 64 per frame");
  classify_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    fr_rise && per_cnt_q >= 10'h0F0 && per_cnt_q <= 10'h110
    |=> ratio_q == CDCR_R256)
    else $error("256 ratio misclassified");
  dec_rate_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    dec_vld[0] |-> $past(tick_q) && $past(phase_q) == 6'h3F)
    else $error("decimated word outside frame boundary");
endmodule
